// >>> sim/mmcaq_check_assertions.sv
`timescale 1ns/10ps
`include "mmcaq_consts.svh"

module mmcaq_check import mmcaq_pkg::*; #(
	parameter int RESEND_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic msg_valid,
	input wire logic [7:0] msg_code,
	input wire logic [7:0] msg_len,
	input wire logic msg_ftype_ok,
	input wire logic msg_rsvd_nz,
	input wire logic msg_rrid_known,
	input wire logic msg_tag_ok,
	input wire logic msg_in_ctx,
	input wire logic node_is_cfg,
	input wire logic nq_reply_sent,
	input wire mmcaq_act_e act_r,
	input wire logic act_valid_r,
	input wire logic log_r,
	input wire logic cancel_io_r,
	input wire logic malert_gen_r,
	input wire logic alert_send_r
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	localparam logic [15:0] RM = `MMCAQ_RRID_MASK;
	localparam logic [15:0] TM = `MMCAQ_TAG_MASK;
	logic known, full, nq_seen_r;
	logic [3:0] ix;
	// long frames, or lengths below every table entry, so the length table order never matters here
	assign known = msg_code != 8'h00 && msg_code <= 8'h0f;
	assign full = msg_valid && known && msg_ftype_ok && msg_len == 8'hff;
	assign ix = msg_code[3:0] - 4'h1;
	// remembers a node query reply since the last hard reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) nq_seen_r <= 1'b0;
		else if (nq_reply_sent) nq_seen_r <= 1'b1;
	end
	resp_timing_a: assert property (msg_valid |=> act_valid_r ##1 !act_valid_r)
		else $error("answer pulse misplaced");
	unknown_code_a: assert property (msg_valid && !known |=> act_r == ACT_ALERT)
		else $error("unknown code not alerted");
	bad_ftype_a: assert property (msg_valid && known && !msg_ftype_ok |=> act_r == ACT_ALERT)
		else $error("bad frame type not alerted");
	short_len_a: assert property (msg_valid && known && msg_ftype_ok && msg_len < 8'h04
		|=> act_r == ACT_ALERT) else $error("short message not alerted");
	long_len_a: assert property (full && !msg_rsvd_nz && msg_rrid_known && msg_tag_ok
		&& msg_in_ctx |=> act_r == ACT_PASS) else $error("long message refused");
	bad_route_a: assert property (full && !node_is_cfg && RM[ix] && !msg_rrid_known
		|=> act_r == ACT_ALERT) else $error("bad route id not alerted");
	bad_tag_a: assert property (full && node_is_cfg && TM[ix] && !msg_tag_ok
		|=> act_r == ACT_DISCARD && log_r) else $error("bad tag not ignored");
	no_ctx_a: assert property (full && (node_is_cfg || !RM[ix] || msg_rrid_known)
		&& (!TM[ix] || msg_tag_ok) && !msg_in_ctx
		|=> act_r == ACT_DISCARD && log_r == $past(node_is_cfg)) else $error("context slip");
	alert_rsvd_a: assert property (full && msg_code == 8'h05 && msg_rsvd_nz && msg_tag_ok
		&& msg_in_ctx && (node_is_cfg || msg_rrid_known)
		|=> act_r == ACT_AREPLY_INV && malert_gen_r) else $error("alert rsvd");
	data_cancel_a: assert property (full && (msg_code == 8'h0d || msg_code == 8'h0f)
		&& msg_rsvd_nz && msg_tag_ok && msg_in_ctx && (node_is_cfg || msg_rrid_known)
		|=> act_r == ACT_DISCARD && cancel_io_r) else $error("data rsvd not cancelled");
	no_nq_a: assert property (!nq_seen_r |-> !alert_send_r)
		else $error("alert sent before node query reply");
endmodule : mmcaq_check

bind mmcaq_top mmcaq_check #(.RESEND_CYC(RESEND_CYC)) u_chk (.sys_clk, .rst_b, .msg_valid,
	.msg_code, .msg_len, .msg_ftype_ok, .msg_rsvd_nz, .msg_rrid_known, .msg_tag_ok,
	.msg_in_ctx, .node_is_cfg, .nq_reply_sent, .act_r, .act_valid_r, .log_r, .cancel_io_r,
	.malert_gen_r, .alert_send_r);

// >>> sim/mmcaq_master_model.sv
`timescale 1ns/10ps

module mmcaq_master_model (
	input wire logic sys_clk,
	input wire logic alert_send_r,
	input wire logic [15:0] alert_tag_r,
	input wire logic [7:0] alert_code_r,
	input wire logic [0:0] alert_port_r,
	input wire logic bad_code,
	output logic [15:0] rpl_tag,
	output logic [7:0] rpl_code,
	output logic [0:0] rpl_port
);
	logic [7:0] code_r = 8'h00;
	logic [15:0] tag_r = 16'h0000;
	logic [0:0] port_r = 1'b0;
	// reply echoes tag and code of the last alert seen
	always_ff @(posedge sys_clk) begin
		if (alert_send_r) begin
			tag_r <= alert_tag_r;
			code_r <= alert_code_r;
			port_r <= alert_port_r;
		end
	end
	// a wrong code only when the bench asks for one
	assign rpl_tag = tag_r;
	assign rpl_code = code_r ^ {8{bad_code}};
	assign rpl_port = port_r;
endmodule : mmcaq_master_model

// >>> sim/tb_mmcaq_top.sv
`timescale 1ns/10ps
`include "mmcaq_consts.svh"

module tb_mmcaq_top import mmcaq_pkg::*;;
	localparam int RC = 20;
	localparam logic [4:0] OK = 5'b10111;
	logic sys_clk = 0, rst_b = 0, msg_valid = 0, msg_ftype_ok = 0, msg_rsvd_nz = 0;
	logic msg_rrid_known = 0, msg_tag_ok = 0, msg_in_ctx = 0, node_is_cfg = 0, bad_code = 0;
	logic nq_reply_sent = 0, node_reset = 0, cfg_set = 0, ext_alert_req = 0;
	logic [7:0] msg_code = 0, msg_len = 0, msg_ctrl = 0, ext_alert_code = 0, rpl_code;
	logic [15:0] msg_chan = 0, cfg_tag = 16'h5a5a, cfg_route = 16'h0c3c, rpl_tag;
	logic [31:0] msg_fdata = 0;
	logic [0:0] msg_port = 0, cfg_port = 0, ext_alert_port = 0, rpl_port, alert_port_r;
	logic [1:0] port_reset = 0;
	mmcaq_act_e act_r;
	logic act_valid_r, log_r, abort_io_r, cancel_io_r, malert_gen_r, alert_send_r;
	logic [7:0] alert_code_r, alert_ctrl_r;
	logic [15:0] alert_tag_r, alert_route_r, alert_chan_r;
	logic [31:0] alert_fdata_r;
	int bad_count = 0, n_checks = 0, n;

	mmcaq_top #(.RESEND_CYC(RC)) uut (.sys_clk, .rst_b, .msg_valid, .msg_code, .msg_len,
		.msg_ftype_ok, .msg_rsvd_nz, .msg_rrid_known, .msg_tag_ok, .msg_in_ctx, .msg_port,
		.msg_ctrl, .msg_chan, .msg_fdata, .rpl_tag, .rpl_code, .rpl_port, .node_is_cfg,
		.nq_reply_sent, .node_reset, .port_reset, .cfg_set, .cfg_port, .cfg_tag, .cfg_route,
		.ext_alert_req, .ext_alert_code, .ext_alert_port, .act_r, .act_valid_r, .log_r,
		.abort_io_r, .cancel_io_r, .malert_gen_r, .alert_send_r, .alert_port_r, .alert_code_r,
		.alert_tag_r, .alert_route_r, .alert_ctrl_r, .alert_chan_r, .alert_fdata_r);
	mmcaq_master_model u_master (.sys_clk, .alert_send_r, .alert_tag_r, .alert_code_r,
		.alert_port_r, .bad_code, .rpl_tag, .rpl_code, .rpl_port);

	initial forever #5 sys_clk = ~sys_clk;

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// one message, answer sampled in the cycle it stands, then one idle cycle
	task automatic msg(input logic [7:0] c, input logic [7:0] l, input logic [4:0] f,
		input logic [2:0] a, input logic [3:0] p);
		@(negedge sys_clk);
		{msg_code, msg_len} = {c, l};
		{msg_ftype_ok, msg_rsvd_nz, msg_rrid_known, msg_tag_ok, msg_in_ctx} = f;
		msg_valid = 1;
		@(negedge sys_clk);
		msg_valid = 0;
		chk("act_valid", 1, act_valid_r);
		chk("act", a, act_r);
		chk("pulses", p, {log_r, abort_io_r, cancel_io_r, malert_gen_r});
		@(negedge sys_clk);
	endtask : msg

	task automatic ext(input logic [7:0] c);
		@(negedge sys_clk);
		{ext_alert_req, ext_alert_code} = {1'b1, c};
		@(negedge sys_clk);
		ext_alert_req = 0;
	endtask : ext

	// bounded wait for an alert send, n counts the cycles waited
	task automatic wait_send(input int lim, output int k);
		k = 0;
		while (k < lim && alert_send_r !== 1'b1) begin
			@(negedge sys_clk);
			k++;
		end
	endtask : wait_send

	function automatic logic [6:0] rsvd_exp(input logic [7:0] c);
		case (c)
			8'h01: return {ACT_PASS, 4'h0};
			8'h02, 8'h08: return {ACT_NONE, 4'h0};
			8'h04, 8'h0a, 8'h0c: return {ACT_DISCARD, 4'h0};
			8'h05: return {ACT_AREPLY_INV, 4'h1};
			8'h0d, 8'h0f: return {ACT_DISCARD, 4'h2};
			default: return {ACT_RESP_INV, 4'h0};
		endcase
	endfunction : rsvd_exp

	task automatic t_order();
		msg(8'h00, 8'h03, 5'b00000, ACT_ALERT, 0);
		msg(8'h20, 8'hff, OK, ACT_ALERT, 0);
		msg(8'h03, 8'hff, 5'b00111, ACT_ALERT, 0);
		msg(8'h03, 8'h03, 5'b10000, ACT_ALERT, 0);
		msg(8'h03, 8'hff, OK, ACT_PASS, 0);
		msg(8'h03, 8'hff, 5'b10011, ACT_ALERT, 0);
		msg(8'h0e, 8'hff, 5'b10110, ACT_DISCARD, 0);
		node_is_cfg = 1;
		msg(8'h03, 8'hff, 5'b10011, ACT_PASS, 0);
		msg(8'h02, 8'hff, 5'b10101, ACT_DISCARD, 4'h8);
		msg(8'h0e, 8'hff, 5'b10101, ACT_DISCARD, 4'hc);
		msg(8'h0e, 8'hff, 5'b10110, ACT_DISCARD, 4'h8);
		$display("test order done");
	endtask : t_order

	task automatic t_rsvd();
		logic [6:0] e;
		for (int i = 1; i < 16; i++) begin
			e = rsvd_exp(i[7:0]);
			msg(i[7:0], 8'hff, 5'b11111, e[6:4], e[3:0]);
		end
		node_is_cfg = 0;
		$display("test reserved done");
	endtask : t_rsvd

	task automatic t_queue();
		ext(8'h40);
		wait_send(30, n);
		chk("dropped", 0, alert_send_r);
		@(negedge sys_clk) nq_reply_sent = 1;
		@(negedge sys_clk) nq_reply_sent = 0;
		ext(8'h41);
		{msg_ctrl, msg_chan, msg_fdata} = {8'ha5, 16'h1234, 32'hdeadbeef};
		msg(8'h00, 8'hff, OK, ACT_ALERT, 0);
		wait_send(10, n);
		chk("held", 0, alert_send_r);
		@(negedge sys_clk) cfg_set = 1;
		@(negedge sys_clk) cfg_set = 0;
		wait_send(6, n);
		chk("sent", 1, alert_send_r);
		chk("head", {8'h41, 16'h5a5a, 16'h0c3c, 1'b0},
			{alert_code_r, alert_tag_r, alert_route_r, alert_port_r});
		chk("frame", 0, {alert_ctrl_r, alert_chan_r, alert_fdata_r});
		@(negedge sys_clk);
		wait_send(RC + 5, n);
		chk("interval", RC - 1, n);
		$display("test queue done");
	endtask : t_queue

	task automatic t_ack();
		bad_code = 1;
		msg(8'h08, 8'hff, OK, ACT_PASS, 0);
		bad_code = 0;
		wait_send(RC + 5, n);
		chk("resend", {8'h41, 1'b1}, {alert_code_r, alert_send_r});
		msg(8'h08, 8'hff, OK, ACT_PASS, 0);
		wait_send(4, n);
		chk("next", {8'h01, 16'h5a5a, 1'b1}, {alert_code_r, alert_tag_r, alert_send_r});
		chk("frame2", {8'ha5, 16'h1234, 32'hdeadbeef},
			{alert_ctrl_r, alert_chan_r, alert_fdata_r});
		msg(8'h08, 8'hff, 5'b11111, ACT_NONE, 0);
		wait_send(RC + 5, n);
		chk("empty", 0, alert_send_r);
		$display("test ack done");
	endtask : t_ack

	task automatic t_preset();
		ext(8'h42);
		wait_send(4, n);
		chk("direct", {8'h42, 1'b1}, {alert_code_r, alert_send_r});
		@(negedge sys_clk) port_reset = 2'b01;
		@(negedge sys_clk) port_reset = 2'b00;
		wait_send(RC + 5, n);
		chk("reset stop", 0, alert_send_r);
		{cfg_port, ext_alert_port} = 2'b11;
		@(negedge sys_clk) cfg_set = 1;
		@(negedge sys_clk) cfg_set = 0;
		ext(8'h44);
		wait_send(4, n);
		chk("port1", {8'h44, 1'b1, 1'b1}, {alert_code_r, alert_port_r, alert_send_r});
		@(negedge sys_clk) node_reset = 1;
		@(negedge sys_clk) node_reset = 0;
		@(negedge sys_clk) cfg_set = 1;
		@(negedge sys_clk) cfg_set = 0;
		ext(8'h43);
		wait_send(RC + 5, n);
		chk("node reset", 0, alert_send_r);
		$display("test port reset done");
	endtask : t_preset

	// generous bound; the whole sequence needs a few hundred cycles
	initial begin
		#(3000 * 10);
		bad_count++;
		test_done();
	end

	initial begin
		repeat (4) @(negedge sys_clk);
		rst_b = 1;
		repeat (3) @(negedge sys_clk);
		t_order();
		t_rsvd();
		t_queue();
		t_ack();
		t_preset();
		test_done();
	end
endmodule : tb_mmcaq_top

// >>> src/mmcaq_consts.svh
`ifndef MMCAQ_CONSTS_SVH
`define MMCAQ_CONSTS_SVH

// clock and resend timing
`define MMCAQ_CLK_NS 10
`define MMCAQ_RESEND_MS 500
`define MMCAQ_RESEND_CYC (`MMCAQ_RESEND_MS * 1000000 / `MMCAQ_CLK_NS)

// geometry of the alert tables
`define MMCAQ_NPORT 2
`define MMCAQ_QDEPTH 4
`define MMCAQ_TMR_W 26

// message_code values, one per message kind
`define MMCAQ_C_QNODE 8'h01
`define MMCAQ_C_QNODE_RPL 8'h02
`define MMCAQ_C_CFGPORT 8'h03
`define MMCAQ_C_RESP 8'h04
`define MMCAQ_C_AALERT 8'h05
`define MMCAQ_C_MALERT 8'h06
`define MMCAQ_C_QUIESCE 8'h07
`define MMCAQ_C_AREPLY 8'h08
`define MMCAQ_C_QPROTO 8'h09
`define MMCAQ_C_QPROTO_RPL 8'h0a
`define MMCAQ_C_QPORT 8'h0b
`define MMCAQ_C_QPORT_RPL 8'h0c
`define MMCAQ_C_DREADY 8'h0d
`define MMCAQ_C_DREPLY 8'h0e
`define MMCAQ_C_DREQ 8'h0f

// defined message lengths in bytes, indexed by kind
`define MMCAQ_LEN_TAB {8'h10, 8'h10, 8'h10, 8'h10, 8'h08, 8'h08, 8'h10, 8'h0c, \
	8'h10, 8'h10, 8'h08, 8'h0c, 8'h10, 8'h08, 8'h04, 8'h04}

// kind masks, bit n stands for kind ordinal n
`define MMCAQ_SUPPORTED_MASK 16'h7fff
`define MMCAQ_RRID_MASK 16'h1555
`define MMCAQ_TAG_MASK 16'h6eaa
`define MMCAQ_DATA_MASK 16'h7000

// alert codes raised by the checker
`define MMCAQ_AC_UNKNOWN 8'h01
`define MMCAQ_AC_SHORT 8'h02
`define MMCAQ_AC_BAD_ROUTE 8'h03

`endif

// >>> src/mmcaq_pkg.sv
package mmcaq_pkg;

	// message kinds; the ordinal indexes the masks and length table
	typedef enum logic [3:0] {
		K_QNODE, K_QNODE_RPL, K_CFGPORT, K_RESP, K_AALERT, K_MALERT,
		K_QUIESCE, K_AREPLY, K_QPROTO, K_QPROTO_RPL, K_QPORT,
		K_QPORT_RPL, K_DREADY, K_DREPLY, K_DREQ, K_UNK
	} mmcaq_kind_e;

	// action chosen for a received message
	typedef enum logic [2:0] {
		ACT_NONE, ACT_PASS, ACT_RESP_INV, ACT_AREPLY_INV, ACT_DISCARD, ACT_ALERT
	} mmcaq_act_e;

endpackage : mmcaq_pkg

// >>> src/mmcaq_port_queue.sv
`timescale 1ns/10ps
`include "mmcaq_consts.svh"

module mmcaq_port_queue import mmcaq_pkg::*; #(
	parameter int RESEND_CYC = `MMCAQ_RESEND_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic enq,
	input wire logic [7:0] enq_code,
	input wire logic [7:0] enq_ctrl,
	input wire logic [15:0] enq_chan,
	input wire logic [31:0] enq_fdata,
	input wire logic path_set,
	input wire logic [15:0] path_tag,
	input wire logic [15:0] path_route,
	input wire logic ack,
	input wire logic [15:0] ack_tag,
	input wire logic [7:0] ack_code,
	input wire logic grant,
	output logic send_req,
	output logic [7:0] head_code,
	output logic [7:0] head_ctrl,
	output logic [15:0] head_chan,
	output logic [31:0] head_fdata,
	output logic [15:0] tag,
	output logic [15:0] route
);
	localparam int AW = $clog2(`MMCAQ_QDEPTH);
	localparam logic [`MMCAQ_TMR_W-1:0] TMR_LOAD = `MMCAQ_TMR_W'(RESEND_CYC - 1);

	logic [7:0] code_q [`MMCAQ_QDEPTH];
	logic [7:0] ctrl_q [`MMCAQ_QDEPTH];
	logic [15:0] chan_q [`MMCAQ_QDEPTH];
	logic [31:0] fdata_q [`MMCAQ_QDEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic valid_r;
	logic outst_r;
	logic [`MMCAQ_TMR_W-1:0] tmr_r;
	logic ack_hit;
	logic do_enq;

	// the reply must name the stored tag and the head's alert code
	assign ack_hit = ack && outst_r && ack_tag == tag && ack_code == head_code;
	// a full table drops the newest alert rather than overwrite a waiting one
	assign do_enq = enq && cnt_r != (AW+1)'(`MMCAQ_QDEPTH);
	// send when path valid, entries waiting and nothing outstanding or timer ran out
	assign send_req = valid_r && cnt_r != '0 && !ack_hit && (!outst_r || tmr_r == '0);
	assign head_code = code_q[rd_r];
	assign head_ctrl = ctrl_q[rd_r];
	assign head_chan = chan_q[rd_r];
	assign head_fdata = fdata_q[rd_r];

	// table storage, no reset needed as count guards it
	always_ff @(posedge clk) begin
		if (do_enq && !clr) begin
			code_q[wr_r] <= enq_code;
			ctrl_q[wr_r] <= enq_ctrl;
			chan_q[wr_r] <= enq_chan;
			fdata_q[wr_r] <= enq_fdata;
		end
	end

	// pointers: append at tail, remove head on a matching reply; a clear empties the table
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else if (clr) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (do_enq)
				wr_r <= wr_r + 1'b1;
			if (ack_hit)
				rd_r <= rd_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(do_enq) - (AW+1)'(ack_hit);
		end
	end

	// path state from a valid port configure; a configure wins over a same-cycle reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_r <= 1'b0;
			tag <= '0;
			route <= '0;
		end else if (path_set) begin
			valid_r <= 1'b1;
			tag <= path_tag;
			route <= path_route;
		end else if (clr) begin
			valid_r <= 1'b0;
		end
	end

	// outstanding alert and its resend timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outst_r <= 1'b0;
			tmr_r <= '0;
		end else if (clr || ack_hit) begin
			outst_r <= 1'b0;
			tmr_r <= '0;
		end else if (grant) begin
			outst_r <= 1'b1;
			tmr_r <= TMR_LOAD;
		end else if (outst_r && tmr_r != '0) begin
			tmr_r <= tmr_r - 1'b1;
		end
	end

endmodule : mmcaq_port_queue

// >>> src/mmcaq_top.sv
`timescale 1ns/10ps
`include "mmcaq_consts.svh"


module mmcaq_top import mmcaq_pkg::*; #(
	parameter int RESEND_CYC = `MMCAQ_RESEND_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic msg_valid,
	input wire logic [7:0] msg_code,
	input wire logic [7:0] msg_len,
	input wire logic msg_ftype_ok,
	input wire logic msg_rsvd_nz,
	input wire logic msg_rrid_known,
	input wire logic msg_tag_ok,
	input wire logic msg_in_ctx,
	input wire logic [0:0] msg_port,
	input wire logic [7:0] msg_ctrl,
	input wire logic [15:0] msg_chan,
	input wire logic [31:0] msg_fdata,
	input wire logic [15:0] rpl_tag,
	input wire logic [7:0] rpl_code,
	input wire logic [0:0] rpl_port,
	input wire logic node_is_cfg,
	input wire logic nq_reply_sent,
	input wire logic node_reset,
	input wire logic [`MMCAQ_NPORT-1:0] port_reset,
	input wire logic cfg_set,
	input wire logic [0:0] cfg_port,
	input wire logic [15:0] cfg_tag,
	input wire logic [15:0] cfg_route,
	input wire logic ext_alert_req,
	input wire logic [7:0] ext_alert_code,
	input wire logic [0:0] ext_alert_port,
	output mmcaq_act_e act_r,
	output logic act_valid_r,
	output logic log_r,
	output logic abort_io_r,
	output logic cancel_io_r,
	output logic malert_gen_r,
	output logic alert_send_r,
	output logic [0:0] alert_port_r,
	output logic [7:0] alert_code_r,
	output logic [15:0] alert_tag_r,
	output logic [15:0] alert_route_r,
	output logic [7:0] alert_ctrl_r,
	output logic [15:0] alert_chan_r,
	output logic [31:0] alert_fdata_r
);
	localparam int NP = `MMCAQ_NPORT;
	localparam logic [127:0] LEN_TAB = `MMCAQ_LEN_TAB;
	localparam logic [15:0] SUP_M = `MMCAQ_SUPPORTED_MASK, RRID_M = `MMCAQ_RRID_MASK;
	localparam logic [15:0] TAG_M = `MMCAQ_TAG_MASK, DATA_M = `MMCAQ_DATA_MASK;

	logic rst_s1_r;
	logic rst_n;
	logic nq_sent_r;
	mmcaq_kind_e kind;
	logic [7:0] def_len;
	mmcaq_act_e act_nxt;
	logic log_nxt;
	logic abort_nxt;
	logic cancel_nxt;
	logic malert_nxt;
	logic raise_nxt;
	logic [7:0] raise_code_nxt;
	logic ack_nxt;
	logic hold_r;
	logic [7:0] hold_code_r;
	logic [0:0] hold_port_r;
	logic enq_any;
	logic [7:0] enq_code;
	logic [0:0] enq_port;
	logic [7:0] enq_ctrl;
	logic [15:0] enq_chan;
	logic [31:0] enq_fdata;
	logic [NP-1:0] req;
	logic [NP-1:0] gnt;
	logic [7:0] h_code [NP];
	logic [7:0] h_ctrl [NP];
	logic [15:0] h_chan [NP];
	logic [31:0] h_fdata [NP];
	logic [15:0] p_tag [NP];
	logic [15:0] p_route [NP];

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// map the received message_code onto a kind
	always_comb begin
		case (msg_code)
			`MMCAQ_C_QNODE: kind = K_QNODE;
			`MMCAQ_C_QNODE_RPL: kind = K_QNODE_RPL;
			`MMCAQ_C_CFGPORT: kind = K_CFGPORT;
			`MMCAQ_C_RESP: kind = K_RESP;
			`MMCAQ_C_AALERT: kind = K_AALERT;
			`MMCAQ_C_MALERT: kind = K_MALERT;
			`MMCAQ_C_QUIESCE: kind = K_QUIESCE;
			`MMCAQ_C_AREPLY: kind = K_AREPLY;
			`MMCAQ_C_QPROTO: kind = K_QPROTO;
			`MMCAQ_C_QPROTO_RPL: kind = K_QPROTO_RPL;
			`MMCAQ_C_QPORT: kind = K_QPORT;
			`MMCAQ_C_QPORT_RPL: kind = K_QPORT_RPL;
			`MMCAQ_C_DREADY: kind = K_DREADY;
			`MMCAQ_C_DREPLY: kind = K_DREPLY;
			`MMCAQ_C_DREQ: kind = K_DREQ;
			default: kind = K_UNK;
		endcase
	end

	assign def_len = LEN_TAB[{kind, 3'b000} +: 8];

	// validity checks; the if chain keeps the fixed order, first hit wins
	always_comb begin
		act_nxt = ACT_NONE;
		log_nxt = 1'b0;
		abort_nxt = 1'b0;
		cancel_nxt = 1'b0;
		malert_nxt = 1'b0;
		raise_nxt = 1'b0;
		raise_code_nxt = 8'h00;
		ack_nxt = 1'b0;
		if (!msg_valid) begin
			act_nxt = ACT_NONE;
		end else if (kind == K_UNK) begin
			act_nxt = ACT_ALERT;
			raise_nxt = 1'b1;
			raise_code_nxt = `MMCAQ_AC_UNKNOWN;
		end else if (!SUP_M[kind] || !msg_ftype_ok) begin
			act_nxt = ACT_ALERT;
			raise_nxt = 1'b1;
			raise_code_nxt = `MMCAQ_AC_UNKNOWN;
		end else if (msg_len < def_len) begin
			act_nxt = ACT_ALERT;
			raise_nxt = 1'b1;
			raise_code_nxt = `MMCAQ_AC_SHORT;
		end else if (!node_is_cfg && RRID_M[kind] && !msg_rrid_known) begin
			act_nxt = ACT_ALERT;
			raise_nxt = 1'b1;
			raise_code_nxt = `MMCAQ_AC_BAD_ROUTE;
		end else if (TAG_M[kind] && !msg_tag_ok) begin
			act_nxt = ACT_DISCARD;
			log_nxt = node_is_cfg;
			abort_nxt = DATA_M[kind];
		end else if (!msg_in_ctx) begin
			act_nxt = ACT_DISCARD;
			log_nxt = node_is_cfg;
		end else if (msg_rsvd_nz) begin
			// reserved content: parse and answer by kind
			case (kind)
				K_QNODE: act_nxt = ACT_PASS;
				K_QNODE_RPL: act_nxt = ACT_NONE;
				K_CFGPORT, K_MALERT, K_QUIESCE, K_QPROTO, K_QPORT, K_DREPLY:
					act_nxt = ACT_RESP_INV;
				K_AALERT: begin
					act_nxt = ACT_AREPLY_INV;
					malert_nxt = 1'b1;
				end
				K_AREPLY: begin
					act_nxt = ACT_NONE;
					ack_nxt = 1'b1;
				end
				K_RESP, K_QPROTO_RPL, K_QPORT_RPL: act_nxt = ACT_DISCARD;
				K_DREADY, K_DREQ: begin
					act_nxt = ACT_DISCARD;
					cancel_nxt = 1'b1;
				end
				default: act_nxt = ACT_NONE;
			endcase
		end else begin
			act_nxt = ACT_PASS;
			ack_nxt = kind == K_AREPLY;
		end
	end

	// registered verdict; pulses last one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_r <= ACT_NONE;
			act_valid_r <= 1'b0;
			log_r <= 1'b0;
			abort_io_r <= 1'b0;
			cancel_io_r <= 1'b0;
			malert_gen_r <= 1'b0;
		end else begin
			act_r <= act_nxt;
			act_valid_r <= msg_valid;
			log_r <= log_nxt;
			abort_io_r <= abort_nxt;
			cancel_io_r <= cancel_nxt;
			malert_gen_r <= malert_nxt;
		end
	end

	// node query reply sent since reset; set wins over a same-cycle reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			nq_sent_r <= 1'b0;
		else if (nq_reply_sent)
			nq_sent_r <= 1'b1;
		else if (node_reset)
			nq_sent_r <= 1'b0;
	end

	// an outside alert that meets a checker alert waits one cycle here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 1'b0;
			hold_code_r <= 8'h00;
			hold_port_r <= 1'b0;
		end else begin
			hold_r <= ext_alert_req && raise_nxt;
			hold_code_r <= ext_alert_code;
			hold_port_r <= ext_alert_port;
		end
	end

	// pick the alert to enqueue: checker first, then held, then outside
	always_comb begin
		enq_code = ext_alert_code;
		enq_port = ext_alert_port;
		enq_ctrl = 8'h00;
		enq_chan = 16'h0000;
		enq_fdata = 32'h0000_0000;
		if (raise_nxt) begin
			enq_code = raise_code_nxt;
			enq_port = msg_port;
			enq_ctrl = msg_ctrl;
			enq_chan = msg_chan;
			enq_fdata = msg_fdata;
		end else if (hold_r) begin
			enq_code = hold_code_r;
			enq_port = hold_port_r;
		end
	end

	// alerts raised before the first node query reply are dropped
	assign enq_any = (raise_nxt || hold_r || ext_alert_req) && nq_sent_r;

	// fixed priority grant, lower port first
	always_comb begin
		gnt = '0;
		for (int i = 0; i < NP; i++) begin
			if (req[i] && gnt == '0)
				gnt[i] = 1'b1;
		end
	end

	// one alert table per port
	for (genvar p = 0; p < NP; p++) begin : g_port
		mmcaq_port_queue #(
			.RESEND_CYC(RESEND_CYC)
		) u_queue (
			.clk(sys_clk),
			.rst_n(rst_n),
			.clr(node_reset || port_reset[p]),
			.enq(enq_any && enq_port == 1'(p)),
			.enq_code(enq_code),
			.enq_ctrl(enq_ctrl),
			.enq_chan(enq_chan),
			.enq_fdata(enq_fdata),
			.path_set(cfg_set && cfg_port == 1'(p)),
			.path_tag(cfg_tag),
			.path_route(cfg_route),
			.ack(ack_nxt && rpl_port == 1'(p)),
			.ack_tag(rpl_tag),
			.ack_code(rpl_code),
			.grant(gnt[p]),
			.send_req(req[p]),
			.head_code(h_code[p]),
			.head_ctrl(h_ctrl[p]),
			.head_chan(h_chan[p]),
			.head_fdata(h_fdata[p]),
			.tag(p_tag[p]),
			.route(p_route[p])
		);
	end

	// build the outgoing alert from the granted head entry
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_send_r <= 1'b0;
			alert_port_r <= 1'b0;
			alert_code_r <= 8'h00;
			alert_tag_r <= 16'h0000;
			alert_route_r <= 16'h0000;
			alert_ctrl_r <= 8'h00;
			alert_chan_r <= 16'h0000;
			alert_fdata_r <= 32'h0000_0000;
		end else begin
			alert_send_r <= gnt != '0;
			for (int i = 0; i < NP; i++) begin
				if (gnt[i]) begin
					alert_port_r <= 1'(i);
					alert_code_r <= h_code[i];
					alert_tag_r <= p_tag[i];
					alert_route_r <= p_route[i];
					alert_ctrl_r <= h_ctrl[i];
					alert_chan_r <= h_chan[i];
					alert_fdata_r <= h_fdata[i];
				end
			end
		end
	end

endmodule : mmcaq_top
